// ===== ext_mem_pkg.sv
package ext_mem_pkg;

	// System address windows.
	localparam logic [31:0] DDR_BASE       = 32'h8000_0000;
	localparam logic [31:0] DDR_SPAN       = 32'h1000_0000;
	localparam logic [31:0] ASYNC_BASE     = 32'h4200_0000;
	localparam logic [31:0] ASYNC_SPAN     = 32'h0800_0000;
	localparam logic [31:0] CS_SPAN        = 32'h0100_0000;
	localparam logic [31:0] CS_STRIDE      = 32'h0200_0000;
	localparam logic [31:0] SHADOW_BASE    = 32'h0200_0000;

	// Reset values of the controller registers.
	localparam logic [31:0] REFRESH_RST    = 32'h0000_0884;
	localparam logic [31:0] TIMING_ONE_RST = 32'h356B_4B9B;
	localparam logic [31:0] TIMING_TWO_RST = 32'h001D_F145;
	localparam logic [31:0] IMPCAL_RST     = 32'h0000_001F;
	localparam logic [31:0] WAIT_CFG_RST   = 32'hF000_0080;
	localparam logic [31:0] WAIT_CFG_RSVD  = 32'hF000_0000;

	// Revision code; the value is arbitrary.
	localparam logic [15:0] REVISION_CODE  = 16'h0001;

	// Register selects on the plain configuration port.
	localparam logic [2:0]  SEL_REFRESH    = 3'h0;
	localparam logic [2:0]  SEL_TIMING_ONE = 3'h1;
	localparam logic [2:0]  SEL_TIMING_TWO = 3'h2;
	localparam logic [2:0]  SEL_IMPCAL     = 3'h3;
	localparam logic [2:0]  SEL_WAIT_CFG   = 3'h4;
	localparam logic [2:0]  SEL_REV_STAT   = 3'h5;

	localparam int          NUM_CS         = 4;

	// One system access request.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} sys_req_t;

	// Decode result.
	typedef enum logic [1:0] {
		TGT_NONE  = 2'b00,
		TGT_DDR   = 2'b01,
		TGT_ASYNC = 2'b10
	} target_t;

endpackage

// ===== cs_decode.sv
module cs_decode
	import ext_mem_pkg::*;
(
	// Request address.
	input  wire logic [31:0]       addr,
	// Window hits, one per chip-select space.
	output logic      [NUM_CS-1:0] cs_hit
);

	// Each space is 16 Mbytes at a 32 Mbyte stride, so the four leave gaps.
	genvar i;
	generate
		for (i = 0; i < NUM_CS; i++) begin : g_cs
			localparam logic [31:0] LO = ASYNC_BASE + CS_STRIDE * i;
			assign cs_hit[i] = (addr >= LO) && (addr < LO + CS_SPAN);
		end
	endgenerate

endmodule

// ===== ext_mem_if.sv
// What this block does
// - DDR2 data bus is 32 bits by default, 16 bits when narrow mode is set.
// - DDR2 accesses decode in a 256 Mbyte window at 80000000h.
// - DDR2 controller runs from the second PLL's first output, not its second.
// - Reset loads refresh control 00000884h and first timing 356B4B9Bh.
// - Reset loads second timing 001DF145h and impedance control 0000001Fh.
// - Asynchronous data bus is 8 bits only.
// - Asynchronous region starts at 42000000h with four chip-select spaces.
// - Only 64 Mbytes reachable; the four spaces are not contiguous.
// - No mirror of the asynchronous space at 02000000h; that range is reserved.
// - A readable revision code and status register exists.
// - Wait configuration resets to F0000080h; upper set bits are inert.
// - Selects active low; select two floats after reset when boot mode nonzero.
module ext_mem_if
	import ext_mem_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              srst,
	// Clock source selection for the DDR2 controller.
	output logic                   ddr_clk_sel_out_one,
	// Boot bus-mode pins.
	input  wire logic [2:0]        boot_bus_mode_pins,
	// Configuration.
	input  wire logic              ddr_narrow_mode,
	input  wire logic              cfg_we,
	input  wire logic [2:0]        cfg_sel,
	input  wire logic [31:0]       cfg_wdata,
	output logic      [31:0]       cfg_rdata,
	// System access request.
	input  wire sys_req_t          req,
	// Decode results.
	output target_t                target,
	output logic                   reserved_hit,
	output logic      [5:0]        ddr_bus_width,
	output logic      [3:0]        async_bus_width,
	// Chip selects, active low with enables.
	output logic      [NUM_CS-1:0] chip_select_n_out,
	output logic      [NUM_CS-1:0] chip_select_n_oe,
	// Register contents.
	output logic      [31:0]       refresh_control_reg,
	output logic      [31:0]       sdram_timing_reg_one,
	output logic      [31:0]       sdram_timing_reg_two,
	output logic      [31:0]       impedance_cal_io_ctrl,
	output logic      [31:0]       async_wait_config_reg
);

	// Next values of the configuration registers.
	logic [31:0]       refresh_next;
	logic [31:0]       timing_one_next;
	logic [31:0]       timing_two_next;
	logic [31:0]       impcal_next;
	logic [31:0]       wait_cfg_next;

	// Window hits from the chip-space decoder.
	logic [NUM_CS-1:0] cs_hit;

	// Boot mode synchroniser, settle marker and the select-two float flag.
	logic [2:0]        mode_sync1_reg;
	logic [2:0]        mode_sync2_reg;
	logic              settle_reg;
	logic              settle_next;
	logic              cs2_float_reg;
	logic              cs2_float_next;

	// Registered selects, drive enables, decode result and readback.
	logic [NUM_CS-1:0] cs_n_reg;
	logic [NUM_CS-1:0] cs_n_next;
	logic [NUM_CS-1:0] cs_oe_reg;
	logic [NUM_CS-1:0] cs_oe_next;
	target_t           target_reg;
	target_t           target_next;
	logic              rsvd_reg;
	logic              rsvd_next;
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;

	// Combinational window compares.
	logic              ddr_hit;
	logic              async_hit;
	logic              shadow_hit;

	// The DDR2 controller is always fed from the first PLL output.
	assign ddr_clk_sel_out_one = 1'b1;

	// Width reporting; narrow mode trades bandwidth for pins.
	assign ddr_bus_width   = ddr_narrow_mode ? 6'h10 : 6'h20;
	assign async_bus_width = 4'h8;

	cs_decode u_cs_decode (
		.addr   (req.addr),
		.cs_hit (cs_hit)
	);

	// Window compares by subtraction avoid overflow at the top of memory.
	assign ddr_hit    = (req.addr - DDR_BASE) < DDR_SPAN;
	assign async_hit  = (req.addr - ASYNC_BASE) < ASYNC_SPAN;
	assign shadow_hit = (req.addr - SHADOW_BASE) < ASYNC_SPAN;

	// Configuration register next values; reserved wait bits stay fixed.
	always_comb begin
		refresh_next    = refresh_control_reg;
		timing_one_next = sdram_timing_reg_one;
		timing_two_next = sdram_timing_reg_two;
		impcal_next     = impedance_cal_io_ctrl;
		wait_cfg_next   = async_wait_config_reg;
		if (cfg_we) begin
			case (cfg_sel)
				SEL_REFRESH:    refresh_next    = cfg_wdata;
				SEL_TIMING_ONE: timing_one_next = cfg_wdata;
				SEL_TIMING_TWO: timing_two_next = cfg_wdata;
				SEL_IMPCAL:     impcal_next     = cfg_wdata;
				SEL_WAIT_CFG: begin
					wait_cfg_next = (cfg_wdata & ~WAIT_CFG_RSVD)
						| WAIT_CFG_RSVD;
				end
				default: ;
			endcase
		end
	end

	// Registers load their documented reset values.
	always_ff @(posedge clk) begin
		if (srst) begin
			refresh_control_reg   <= REFRESH_RST;
			sdram_timing_reg_one  <= TIMING_ONE_RST;
			sdram_timing_reg_two  <= TIMING_TWO_RST;
			impedance_cal_io_ctrl <= IMPCAL_RST;
			async_wait_config_reg <= WAIT_CFG_RST;
		end else begin
			refresh_control_reg   <= refresh_next;
			sdram_timing_reg_one  <= timing_one_next;
			sdram_timing_reg_two  <= timing_two_next;
			impedance_cal_io_ctrl <= impcal_next;
			async_wait_config_reg <= wait_cfg_next;
		end
	end

	// Boot mode pins come from outside, so they pass two flip-flops.
	// No reset here: the straps settle while reset is held, and only the
	// first edge after release reads them.
	always_ff @(posedge clk) begin
		mode_sync1_reg <= boot_bus_mode_pins;
		mode_sync2_reg <= mode_sync1_reg;
	end

	// Decode, select and readback next values.
	always_comb begin
		settle_next    = 1'b1;
		cs2_float_next = cs2_float_reg;
		if (!settle_reg) begin
			cs2_float_next = (mode_sync2_reg != 3'h0);
		end
		target_next = TGT_NONE;
		rsvd_next   = 1'b0;
		cs_n_next   = {NUM_CS{1'b1}};
		if (req.valid) begin
			if (ddr_hit) begin
				target_next = TGT_DDR;
			end else if (async_hit && (cs_hit != '0)) begin
				target_next = TGT_ASYNC;
				cs_n_next   = ~cs_hit;
			end else if (shadow_hit) begin
				// The reserved range is only flagged; no select is driven.
				rsvd_next = 1'b1;
			end
			// Region gaps fall through with every select high.
		end
		// A select drives once used; before that, only select two may drive.
		// Leaving the others released lets the board pull-ups hold them
		// inactive, at the cost of needing those resistors on the board.
		cs_oe_next = cs_oe_reg | ~cs_n_next;
		if (settle_reg && !cs2_float_reg) begin
			cs_oe_next[0] = 1'b1;
		end
		// Readback of the selected register, one cycle behind the select.
		case (cfg_sel)
			SEL_REFRESH:    rdata_next = refresh_control_reg;
			SEL_TIMING_ONE: rdata_next = sdram_timing_reg_one;
			SEL_TIMING_TWO: rdata_next = sdram_timing_reg_two;
			SEL_IMPCAL:     rdata_next = impedance_cal_io_ctrl;
			SEL_WAIT_CFG:   rdata_next = async_wait_config_reg;
			SEL_REV_STAT: begin
				rdata_next = {REVISION_CODE, 13'h0, cs2_float_reg,
					ddr_narrow_mode, settle_reg};
			end
			default:        rdata_next = 32'h0000_0000;
		endcase
	end

	// Select outputs idle high; drivers start released after reset.
	always_ff @(posedge clk) begin
		if (srst) begin
			settle_reg    <= 1'b0;
			cs2_float_reg <= 1'b1;
			cs_n_reg      <= {NUM_CS{1'b1}};
			cs_oe_reg     <= {NUM_CS{1'b0}};
			target_reg    <= TGT_NONE;
			rsvd_reg      <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
		end else begin
			settle_reg    <= settle_next;
			cs2_float_reg <= cs2_float_next;
			cs_n_reg      <= cs_n_next;
			cs_oe_reg     <= cs_oe_next;
			target_reg    <= target_next;
			rsvd_reg      <= rsvd_next;
			rdata_reg     <= rdata_next;
		end
	end

	// Outputs come straight from the registers above.
	assign chip_select_n_out = cs_n_reg;
	assign chip_select_n_oe  = cs_oe_reg;
	assign target            = target_reg;
	assign reserved_hit      = rsvd_reg;
	assign cfg_rdata         = rdata_reg;

endmodule

// ===== ext_mem_if_props.sv
module ext_mem_if_props
	import ext_mem_pkg::*;
(
	// Clock and reset.
	input wire logic              clk,
	input wire logic              srst,
	// Watched outputs and their causes.
	input wire logic              ddr_clk_sel_out_one,
	input wire logic              ddr_narrow_mode,
	input wire sys_req_t          req,
	input wire target_t           target,
	input wire logic              reserved_hit,
	input wire logic [5:0]        ddr_bus_width,
	input wire logic [3:0]        async_bus_width,
	input wire logic [NUM_CS-1:0] chip_select_n_out,
	input wire logic [NUM_CS-1:0] chip_select_n_oe,
	input wire logic [31:0]       refresh_control_reg,
	input wire logic [31:0]       async_wait_config_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// A request to the first chip space, then its select one cycle later.
	sequence s_cs_req; req.valid && req.addr[31:24] == 8'h42; endsequence
	sequence s_cs_ans;
		chip_select_n_out == 4'he && chip_select_n_oe[0];
	endsequence
	property p_cs_two; s_cs_req |=> s_cs_ans; endproperty
	a_cs_two: assert property (p_cs_two) else $error("select two wrong");
	property p_ddr;
		req.valid && req.addr[31:28] == 4'h8 |=> target == TGT_DDR;
	endproperty
	a_ddr: assert property (p_ddr) else $error("ddr decode wrong");
	property p_gap;
		req.valid && req.addr[31:24] == 8'h43 |=>
			target == TGT_NONE && &chip_select_n_out;
	endproperty
	a_gap: assert property (p_gap) else $error("gap selected");
	property p_shadow;
		req.valid && req.addr[31:24] == 8'h02 |=> reserved_hit && !target;
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow decoded");
	property p_width;
		ddr_bus_width == (ddr_narrow_mode ? 6'h10 : 6'h20) &&
			async_bus_width == 4'h8;
	endproperty
	a_width: assert property (p_width) else $error("bus width wrong");
	property p_clk; ddr_clk_sel_out_one; endproperty
	a_clk: assert property (p_clk) else $error("ddr clock source");
	property p_rst;
		$fell(srst) |-> refresh_control_reg == REFRESH_RST;
	endproperty
	a_rst: assert property (p_rst) else $error("refresh reset value");
	property p_wait; async_wait_config_reg[31:28] == 4'hf; endproperty
	a_wait: assert property (p_wait) else $error("wait upper bits");
endmodule

bind ext_mem_if ext_mem_if_props i_ext_mem_if_props (.clk, .srst,
	.ddr_clk_sel_out_one, .ddr_narrow_mode, .req, .target, .reserved_hit,
	.ddr_bus_width, .async_bus_width, .chip_select_n_out, .chip_select_n_oe,
	.refresh_control_reg, .async_wait_config_reg);

// ===== ext_mem_partner.sv
module ext_mem_partner
	import ext_mem_pkg::*;
(
	// Select drivers of the block.
	input  wire logic [NUM_CS-1:0] cs_n_out,
	input  wire logic [NUM_CS-1:0] cs_n_oe,
	// Levels the memory parts see.
	output logic      [NUM_CS-1:0] cs_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// Board pull-ups keep an undriven select inactive, so a float reads high.
	assign cs_line = cs_n_out | ~cs_n_oe;
endmodule

// ===== test_ext_mem_if.sv
module test_ext_mem_if
	import ext_mem_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic [2:0]        boot_bus_mode_pins = 3'h0;
	logic              ddr_narrow_mode = 1'b0;
	logic              cfg_we = 1'b0;
	logic [2:0]        cfg_sel = 3'h0;
	logic [31:0]       cfg_wdata = 32'h0000_0000;
	sys_req_t          req = '0;
	logic [31:0]       lfsr = 32'h0000_9478;
	int                fail_count = 0;
	int                num_checks = 0;
	target_t           target;
	logic              reserved_hit, ddr_clk_sel_out_one;
	logic [5:0]        ddr_bus_width;
	logic [3:0]        async_bus_width;
	logic [NUM_CS-1:0] chip_select_n_out, chip_select_n_oe, cs_line;
	logic [31:0]       cfg_rdata, refresh_control_reg, sdram_timing_reg_one;
	logic [31:0]       sdram_timing_reg_two, impedance_cal_io_ctrl;
	logic [31:0]       async_wait_config_reg;
	logic [31:0]       corner [12] = '{32'h8000_0000, 32'h8FFF_FFFF,
		32'h9000_0000, 32'h4200_0000, 32'h43FF_FFFF, 32'h4400_1234,
		32'h46AB_CDEF, 32'h48FF_FFFF, 32'h4900_0000, 32'h0200_0000,
		32'h09FF_FFFF, 32'h0A00_0000};

	always #10 clk = ~clk;

	ext_mem_if i_ext_mem_if (.clk, .srst, .ddr_clk_sel_out_one,
		.boot_bus_mode_pins, .ddr_narrow_mode, .cfg_we, .cfg_sel, .cfg_wdata,
		.cfg_rdata, .req, .target, .reserved_hit, .ddr_bus_width,
		.async_bus_width, .chip_select_n_out, .chip_select_n_oe,
		.refresh_control_reg, .sdram_timing_reg_one, .sdram_timing_reg_two,
		.impedance_cal_io_ctrl, .async_wait_config_reg);
	ext_mem_partner i_ext_mem_partner (.cs_n_out(chip_select_n_out),
		.cs_n_oe(chip_select_n_oe), .cs_line);

	// Shift register step for repeatable test data.
	function automatic logic [31:0] next_rand(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Expected {reserved, target, selects} for one valid request.
	function automatic logic [6:0] exp_dec(logic [31:0] a);
		if (a[31:28] == 4'h8) return {1'b0, TGT_DDR, 4'hf};
		if (a[31:24] inside {8'h42, 8'h44, 8'h46, 8'h48})
			return {1'b0, TGT_ASYNC, ~(4'h1 << (a[27:25] - 3'h1))};
		return {a[31:24] >= 8'h02 && a[31:24] <= 8'h09, TGT_NONE, 4'hf};
	endfunction

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Boot pins settle before release; reset values and select drive follow.
	task automatic do_reset(logic [2:0] mode);
		srst <= 1'b1;
		boot_bus_mode_pins <= mode;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(chip_select_n_oe, {3'h0, mode == 3'h0});
		chk(cs_line, 4'hf);
		chk(refresh_control_reg, REFRESH_RST);
		chk(sdram_timing_reg_one, TIMING_ONE_RST);
		chk(sdram_timing_reg_two, TIMING_TWO_RST);
		chk(impedance_cal_io_ctrl, IMPCAL_RST);
		chk(async_wait_config_reg, WAIT_CFG_RST);
		$display("reset test done");
	endtask

	task automatic access(logic [31:0] a);
		@(posedge clk);
		req <= '{valid: 1'b1, write: a[0], addr: a};
		@(posedge clk);
		req.valid <= 1'b0;
		@(negedge clk);
		chk({reserved_hit, target, chip_select_n_out}, exp_dec(a));
	endtask

	// Write, then read back the same select two edges later under a mask.
	task automatic cfg(logic [2:0] s, logic [31:0] d, e, m);
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_sel <= s;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_we <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(cfg_rdata & m, e);
	endtask

	initial begin
		do_reset(3'h0);
		chk(ddr_clk_sel_out_one, 1'b1);
		for (int n = 0; n < 2; n++) begin
			@(posedge clk);
			ddr_narrow_mode <= n[0];
			@(negedge clk);
			chk({async_bus_width, ddr_bus_width}, {4'h8, n ? 6'h10 : 6'h20});
		end
		foreach (corner[i]) access(corner[i]);
		chk(chip_select_n_oe, 4'hf);
		repeat (60) begin
			lfsr = next_rand(lfsr);
			access(lfsr[0] ? {4'h4, lfsr[27:0]} : lfsr);
		end
		$display("decode test done");
		for (int s = 0; s < 5; s++) begin
			lfsr = next_rand(lfsr);
			cfg(s[2:0], lfsr, s == 4 ? lfsr | WAIT_CFG_RSVD : lfsr, '1);
		end
		cfg(SEL_REV_STAT, lfsr, {REVISION_CODE, 16'h0002}, 32'hFFFF_0006);
		$display("config test done");
		@(posedge clk);
		do_reset(3'h5);
		end_of_test();
	end

	// Watchdog against a hung run.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
endmodule
